// ===== usbeh_regs.svh
`ifndef USBEH_REGS_SVH
`define USBEH_REGS_SVH

// ************************************************************
// Register indices (the bus byte address is four times each index)
// ************************************************************
`define USBEH_IDX_EP12_CTRL2   8'h47
`define USBEH_IDX_FUNC_ADDR    8'h48
`define USBEH_IDX_EP0_IRQ      8'h49
`define USBEH_IDX_EP12_IRQ     8'h4A
`define USBEH_IDX_EP0_CTRL     8'h4B
`define USBEH_IDX_EP12_CTRL    8'h4C
`define USBEH_IDX_EP0_STATUS   8'h4D
`define USBEH_ADDR_W           10

// ************************************************************
// Field positions
// ************************************************************
`define USBEH_B_TX_FLAG        7
`define USBEH_B_RX_FLAG        6
`define USBEH_B_TX_IE          3
`define USBEH_B_RX_IE          2
`define USBEH_B_TX_CLR         1
`define USBEH_B_RX_CLR         0
`define USBEH_B_TOGGLE         7
`define USBEH_B_STALL0         6
`define USBEH_B_ENDSEL         6
`define USBEH_B_TXE            5
`define USBEH_B_RXE            4
`define USBEH_B_SEQ_SEEN       7
`define USBEH_B_SETUP_SEEN     6
`define USBEH_B_TXFIRST        5
`define USBEH_B_TXFIRST_CLR    4
`define USBEH_B_EP2_EN         3
`define USBEH_B_EP1_EN         2
`define USBEH_B_EP2_STALL      1
`define USBEH_B_EP1_STALL      0
`define USBEH_B_FUNC_EN        7

// ************************************************************
// Reset values
// ************************************************************
`define USBEH_RST_BYTE         8'h00
`define USBEH_RST_NIB          4'h0
`define USBEH_RST_ADDR         7'h00

`endif

// ===== usbeh_pkg.sv
package usbeh_pkg;

    // Handshake that the serial engine must return for a token
    typedef enum logic [1:0] {
        USBEH_HS_ACK   = 2'b00,
        USBEH_HS_NAK   = 2'b01,
        USBEH_HS_STALL = 2'b10,
        USBEH_HS_NONE  = 2'b11
    } usbeh_hs_t;

    // Token kinds delivered by the serial engine
    typedef enum logic [1:0] {
        USBEH_TOK_OUT   = 2'b00,
        USBEH_TOK_IN    = 2'b01,
        USBEH_TOK_SETUP = 2'b10,
        USBEH_TOK_SOF   = 2'b11
    } usbeh_tok_t;

    // Bus slave phases
    typedef enum logic [0:0] {
        USBEH_BUS_IDLE = 1'b0,
        USBEH_BUS_ACK  = 1'b1
    } usbeh_bus_t;

endpackage

// ===== usbeh_flag.sv
`timescale 1ns/10ps
`include "usbeh_regs.svh"

// Sticky flag: hardware set wins over a software clear in the same cycle
module usbeh_flag (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_q
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
        end else if (set_i) begin
            flag_q <= 1'b1;
        end else if (clr_i) begin
            flag_q <= 1'b0;
        end
    end
endmodule

// ===== usbeh_wb_slave.sv
`timescale 1ns/10ps
`include "usbeh_regs.svh"

// ************************************************************
// Classic Wishbone slave: one wait state, ack for exactly one cycle
// ************************************************************
module usbeh_wb_slave (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [`USBEH_ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    output logic                          wb_ack_o,
    output logic                          wr_stb,
    output logic                          rd_stb,
    output logic [7:0]                    reg_idx
);
    import usbeh_pkg::*;
    usbeh_bus_t state_q;
    logic       req;

    assign req     = wb_cyc_i && wb_stb_i;
    // Byte address is four times the printed index; low byte lane only
    assign reg_idx = wb_adr_i[`USBEH_ADDR_W-1:2];
    assign wb_ack_o = (state_q == USBEH_BUS_ACK);
    assign wr_stb  = wb_ack_o && wb_we_i && wb_sel_i[0];
    assign rd_stb  = wb_ack_o && !wb_we_i;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= USBEH_BUS_IDLE;
        end else begin
            unique case (state_q)
                USBEH_BUS_IDLE: begin
                    if (req) begin
                        state_q <= USBEH_BUS_ACK;
                    end
                end
                USBEH_BUS_ACK: begin
                    state_q <= USBEH_BUS_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== usbeh_endpoint.sv
`timescale 1ns/10ps
`include "usbeh_regs.svh"

// Operation
// - EP0 tx flag set on ACKed IN
// - Write 1 clears EP0 tx flag
// - NAK EP0 IN if disabled or flagged
// - EP0 rx flag set on ACKed data
// - Write 1 clears EP0 rx flag
// - NAK EP0 OUT if disabled or flagged
// - EP0 flags raise enabled interrupts
// - Shared EP1/2 tx flag on ACK
// - Write 1 clears shared tx flag
// - NAK EP1/2 IN if disabled or flagged
// - Shared flag raises enabled interrupt
// - EP0 toggle picks DATA1 or DATA0
// - EP0 stall; SETUP clears it
// - EP0 transmit byte count register
// - EP1/2 toggle picks DATA1 or DATA0
// - Select bit steers shared buffer
// - EP1/2 transmit byte count register
// - Received toggle and SETUP status
// - Tx-first flag, write 1 clears
// - Received byte count, reset-immune
// - EP1/EP2 individual enables gate IN
// - EP1/EP2 force stall
// - Function enable and 7-bit address
module usbeh_endpoint (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [`USBEH_ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic [31:0]                   wb_dat_o,
    output logic                          wb_ack_o,
    input  wire logic                     tok_valid,
    input  wire usbeh_pkg::usbeh_tok_t    tok_kind,
    input  wire logic [6:0]               tok_addr,
    input  wire logic [3:0]               tok_endp,
    output usbeh_pkg::usbeh_hs_t          hs_reply,
    output logic                          tx_data1,
    output logic [3:0]                    tx_len,
    output logic                          tx_ep2,
    input  wire logic                     tx_acked,
    input  wire logic                     rx_done,
    input  wire logic                     rx_data1,
    input  wire logic [3:0]               rx_len,
    output logic [6:0]                    func_address,
    output logic                          irq
);
    import usbeh_pkg::*;

    // ************************************************************
    // Bus access
    // ************************************************************
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] reg_idx;
    logic [7:0] wd;

    usbeh_wb_slave u_bus (
        .clk      (clk),
        .rst_b    (rst_b),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_ack_o (wb_ack_o),
        .wr_stb   (wr_stb),
        .rd_stb   (rd_stb),
        .reg_idx  (reg_idx)
    );

    assign wd = wb_dat_i[7:0];

    // ************************************************************
    // Control registers
    // ************************************************************
    logic       ep0_tx_toggle_q;
    logic       ep0_force_stall_q;
    logic       ep0_tx_enable_q;
    logic       ep0_rx_enable_q;
    logic [3:0] ep0_tx_byte_count_q;
    logic       ep12_tx_toggle_q;
    logic       shared_buffer_endpoint_select_q;
    logic       ep12_tx_enable_q;
    logic [3:0] ep12_tx_byte_count_q;
    logic       ep0_tx_irq_enable_q;
    logic       ep0_rx_irq_enable_q;
    logic       ep12_tx_irq_enable_q;
    logic       ep1_enable_q;
    logic       ep2_enable_q;
    logic       ep1_force_stall_q;
    logic       ep2_force_stall_q;
    logic       function_enable_q;
    logic [6:0] function_address_q;
    logic       setup_tok;

    assign setup_tok = tok_valid && (tok_kind == USBEH_TOK_SETUP) && function_enable_q
                       && (tok_addr == function_address_q) && (tok_endp == 4'h0);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ep0_force_stall_q <= 1'b0;
        end else if (setup_tok) begin
            ep0_force_stall_q <= 1'b0;
        end else if (wr_stb && reg_idx == `USBEH_IDX_EP0_CTRL) begin
            ep0_force_stall_q <= wd[`USBEH_B_STALL0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ep0_tx_toggle_q     <= 1'b0;
            ep0_tx_enable_q     <= 1'b0;
            ep0_rx_enable_q     <= 1'b0;
            ep0_tx_byte_count_q <= `USBEH_RST_NIB;
        end else if (wr_stb && reg_idx == `USBEH_IDX_EP0_CTRL) begin
            ep0_tx_toggle_q     <= wd[`USBEH_B_TOGGLE];
            ep0_tx_enable_q     <= wd[`USBEH_B_TXE];
            ep0_rx_enable_q     <= wd[`USBEH_B_RXE];
            ep0_tx_byte_count_q <= wd[3:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ep12_tx_toggle_q                <= 1'b0;
            shared_buffer_endpoint_select_q <= 1'b0;
            ep12_tx_enable_q                <= 1'b0;
            ep12_tx_byte_count_q            <= `USBEH_RST_NIB;
        end else if (wr_stb && reg_idx == `USBEH_IDX_EP12_CTRL) begin
            ep12_tx_toggle_q                <= wd[`USBEH_B_TOGGLE];
            shared_buffer_endpoint_select_q <= wd[`USBEH_B_ENDSEL];
            ep12_tx_enable_q                <= wd[`USBEH_B_TXE];
            ep12_tx_byte_count_q            <= wd[3:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ep0_tx_irq_enable_q  <= 1'b0;
            ep0_rx_irq_enable_q  <= 1'b0;
            ep12_tx_irq_enable_q <= 1'b0;
        end else if (wr_stb && reg_idx == `USBEH_IDX_EP0_IRQ) begin
            ep0_tx_irq_enable_q <= wd[`USBEH_B_TX_IE];
            ep0_rx_irq_enable_q <= wd[`USBEH_B_RX_IE];
        end else if (wr_stb && reg_idx == `USBEH_IDX_EP12_IRQ) begin
            ep12_tx_irq_enable_q <= wd[`USBEH_B_TX_IE];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ep1_enable_q       <= 1'b0;
            ep2_enable_q       <= 1'b0;
            ep1_force_stall_q  <= 1'b0;
            ep2_force_stall_q  <= 1'b0;
            function_enable_q  <= 1'b0;
            function_address_q <= `USBEH_RST_ADDR;
        end else if (wr_stb && reg_idx == `USBEH_IDX_EP12_CTRL2) begin
            ep1_enable_q      <= wd[`USBEH_B_EP1_EN];
            ep2_enable_q      <= wd[`USBEH_B_EP2_EN];
            ep1_force_stall_q <= wd[`USBEH_B_EP1_STALL];
            ep2_force_stall_q <= wd[`USBEH_B_EP2_STALL];
        end else if (wr_stb && reg_idx == `USBEH_IDX_FUNC_ADDR) begin
            function_enable_q  <= wd[`USBEH_B_FUNC_EN];
            function_address_q <= wd[6:0];
        end
    end

    // ************************************************************
    // Token decode and handshake choice
    // ************************************************************
    logic       for_us;
    logic       ep0_tok;
    logic       ep1_tok;
    logic       ep2_tok;
    logic       is_in;
    logic       is_out;
    usbeh_hs_t  hs_d;

    assign for_us  = tok_valid && function_enable_q && (tok_addr == function_address_q);
    assign ep0_tok = for_us && (tok_endp == 4'h0);
    assign ep1_tok = for_us && (tok_endp == 4'h1);
    assign ep2_tok = for_us && (tok_endp == 4'h2);
    assign is_in   = (tok_kind == USBEH_TOK_IN);
    assign is_out  = (tok_kind == USBEH_TOK_OUT);

    logic ep0_tx_done_flag;
    logic ep0_rx_done_flag;
    logic ep12_tx_done_flag;
    logic tx_before_rx_flag;

    always_comb begin
        hs_d = USBEH_HS_NONE;
        if (ep0_tok && (is_in || is_out)) begin
            if (ep0_force_stall_q) begin
                hs_d = USBEH_HS_STALL;
            end else if (is_in && (!ep0_tx_enable_q || ep0_tx_done_flag)) begin
                hs_d = USBEH_HS_NAK;
            end else if (is_out && (!ep0_rx_enable_q || ep0_rx_done_flag)) begin
                hs_d = USBEH_HS_NAK;
            end else begin
                hs_d = USBEH_HS_ACK;
            end
        end else if (ep0_tok) begin
            hs_d = USBEH_HS_ACK;
        end else if ((ep1_tok || ep2_tok) && (is_in || is_out)) begin
            if ((ep1_tok && ep1_force_stall_q) || (ep2_tok && ep2_force_stall_q)) begin
                hs_d = USBEH_HS_STALL;
            end else if (!is_in || (ep1_tok ? !ep1_enable_q : !ep2_enable_q)) begin
                hs_d = USBEH_HS_NONE;
            end else if (!ep12_tx_enable_q || ep12_tx_done_flag) begin
                hs_d = USBEH_HS_NAK;
            // buffer owned by the other endpoint
            end else if (ep2_tok != shared_buffer_endpoint_select_q) begin
                hs_d = USBEH_HS_NAK;
            end else begin
                hs_d = USBEH_HS_ACK;
            end
        end
    end

    // ************************************************************
    // Reply and packet attributes, held until the next token
    // ************************************************************
    logic last_ep0_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hs_reply   <= USBEH_HS_NONE;
            tx_data1   <= 1'b0;
            tx_len     <= `USBEH_RST_NIB;
            tx_ep2     <= 1'b0;
            last_ep0_q <= 1'b0;
        end else if (tok_valid) begin
            hs_reply   <= hs_d;
            last_ep0_q <= ep0_tok;
            tx_ep2     <= ep2_tok;
            tx_data1   <= ep0_tok ? ep0_tx_toggle_q : ep12_tx_toggle_q;
            tx_len     <= ep0_tok ? ep0_tx_byte_count_q : ep12_tx_byte_count_q;
        end
    end

    // ************************************************************
    // Flags
    // ************************************************************
    logic wr_irq0;
    logic wr_irq1;
    logic wr_stat;
    logic ep0_tx_set;
    logic ep0_rx_set;

    assign wr_irq0    = wr_stb && reg_idx == `USBEH_IDX_EP0_IRQ;
    assign wr_irq1    = wr_stb && reg_idx == `USBEH_IDX_EP12_IRQ;
    assign wr_stat    = wr_stb && reg_idx == `USBEH_IDX_EP0_STATUS;
    assign ep0_tx_set = tx_acked && last_ep0_q;
    assign ep0_rx_set = rx_done && last_ep0_q;

    usbeh_flag u_ep0_tx (
        .clk    (clk),
        .rst_b  (rst_b),
        .set_i  (ep0_tx_set),
        .clr_i  (wr_irq0 && wd[`USBEH_B_TX_CLR]),
        .flag_q (ep0_tx_done_flag)
    );

    usbeh_flag u_ep0_rx (
        .clk    (clk),
        .rst_b  (rst_b),
        .set_i  (ep0_rx_set),
        .clr_i  (wr_irq0 && wd[`USBEH_B_RX_CLR]),
        .flag_q (ep0_rx_done_flag)
    );

    usbeh_flag u_ep12_tx (
        .clk    (clk),
        .rst_b  (rst_b),
        .set_i  (tx_acked && !last_ep0_q),
        .clr_i  (wr_irq1 && wd[`USBEH_B_TX_CLR]),
        .flag_q (ep12_tx_done_flag)
    );

    // tx-first when rx completes over a pending tx flag
    usbeh_flag u_txfirst (
        .clk    (clk),
        .rst_b  (rst_b),
        .set_i  (ep0_rx_set && ep0_tx_done_flag),
        .clr_i  (wr_stat && wd[`USBEH_B_TXFIRST_CLR]),
        .flag_q (tx_before_rx_flag)
    );

    // ************************************************************
    // Receive status; no reset so the last packet survives it
    // ************************************************************
    logic       ep0_rx_toggle_seen_q;
    logic       ep0_setup_seen_q;
    logic [3:0] ep0_rx_byte_count_q;

    always_ff @(posedge clk) begin
        if (ep0_tok) begin
            ep0_setup_seen_q <= (tok_kind == USBEH_TOK_SETUP);
        end
        if (ep0_rx_set) begin
            ep0_rx_toggle_seen_q <= rx_data1;
            ep0_rx_byte_count_q  <= rx_len;
        end
    end

    // ************************************************************
    // Read data and interrupt
    // ************************************************************
    logic [7:0] rd_d;

    always_comb begin
        rd_d = `USBEH_RST_BYTE;
        unique case (reg_idx)
            `USBEH_IDX_EP12_CTRL2: rd_d = {4'h0, ep2_enable_q, ep1_enable_q,
                                           ep2_force_stall_q, ep1_force_stall_q};
            `USBEH_IDX_FUNC_ADDR:  rd_d = {function_enable_q, function_address_q};
            `USBEH_IDX_EP0_IRQ:    rd_d = {ep0_tx_done_flag, ep0_rx_done_flag, 2'b00,
                                           ep0_tx_irq_enable_q, ep0_rx_irq_enable_q, 2'b00};
            `USBEH_IDX_EP12_IRQ:   rd_d = {ep12_tx_done_flag, 3'b000,
                                           ep12_tx_irq_enable_q, 3'b000};
            `USBEH_IDX_EP0_CTRL:   rd_d = {ep0_tx_toggle_q, ep0_force_stall_q,
                                           ep0_tx_enable_q, ep0_rx_enable_q,
                                           ep0_tx_byte_count_q};
            `USBEH_IDX_EP12_CTRL:  rd_d = {ep12_tx_toggle_q, shared_buffer_endpoint_select_q,
                                           ep12_tx_enable_q, 1'b0, ep12_tx_byte_count_q};
            `USBEH_IDX_EP0_STATUS: rd_d = {ep0_rx_toggle_seen_q, ep0_setup_seen_q,
                                           tx_before_rx_flag, 1'b0, ep0_rx_byte_count_q};
            default:               rd_d = `USBEH_RST_BYTE;
        endcase
    end

    // Data comes from a flop; unmapped addresses read zero and writes drop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            wb_dat_o <= {24'h00_0000, rd_d};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= (ep0_tx_done_flag && ep0_tx_irq_enable_q)
                 || (ep0_rx_done_flag && ep0_rx_irq_enable_q)
                 || (ep12_tx_done_flag && ep12_tx_irq_enable_q);
        end
    end

    assign func_address = function_address_q;

endmodule

// ===== usbeh_endpoint_props.sv
`timescale 1ns/10ps

// ********************
// Port checker
// ********************
module usbeh_endpoint_props (
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire logic                  tok_valid,
    input wire usbeh_pkg::usbeh_tok_t tok_kind,
    input wire logic [6:0]            tok_addr,
    input wire logic [3:0]            tok_endp,
    input wire usbeh_pkg::usbeh_hs_t  hs_reply,
    input wire logic                  tx_data1,
    input wire logic [3:0]            tx_len,
    input wire logic [6:0]            func_address
);
    import usbeh_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held beyond one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    rdata_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    hs_hold_a: assert property (!tok_valid |=> $stable(hs_reply))
        else $error("handshake changed without token");
    tx_hold_a: assert property (!tok_valid |=> $stable(tx_len) && $stable(tx_data1))
        else $error("tx length or toggle changed without token");
    addr_miss_a: assert property (tok_valid && tok_addr != func_address
        |=> hs_reply == USBEH_HS_NONE) else $error("answered foreign address");
    setup_ep12_a: assert property (tok_valid && tok_kind == USBEH_TOK_SETUP
        && tok_endp != 4'h0 |=> hs_reply == USBEH_HS_NONE) else $error("setup on ep1/2");
    out_ep12_a: assert property (tok_valid && tok_kind == USBEH_TOK_OUT
        && tok_endp inside {4'h1, 4'h2} |=> hs_reply inside {USBEH_HS_NONE, USBEH_HS_STALL})
        else $error("bad reply to out on ep1/2");
    setup_ack_a: assert property (tok_valid && tok_kind == USBEH_TOK_SETUP
        && tok_endp == 4'h0 && tok_addr == func_address
        |=> hs_reply inside {USBEH_HS_ACK, USBEH_HS_NONE}) else $error("setup not acked");
endmodule

bind usbeh_endpoint usbeh_endpoint_props u_props (
    .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tok_valid(tok_valid),
    .tok_kind(tok_kind), .tok_addr(tok_addr), .tok_endp(tok_endp), .hs_reply(hs_reply),
    .tx_data1(tx_data1), .tx_len(tx_len), .func_address(func_address)
);

// ===== usbeh_host_model.sv
`timescale 1ns/10ps

// ********************
// Host controller model
// ********************
module usbeh_host_model (
    input  wire logic             clk,
    output logic                  tok_valid,
    output usbeh_pkg::usbeh_tok_t tok_kind,
    output logic [6:0]            tok_addr,
    output logic [3:0]            tok_endp,
    output logic                  tx_acked,
    output logic                  rx_done,
    output logic                  rx_data1,
    output logic [3:0]            rx_len
);
    import usbeh_pkg::*;
    initial begin
        tok_kind = USBEH_TOK_SOF;
        {tok_valid, tok_addr, tok_endp, tx_acked, rx_done, rx_data1, rx_len} = '0;
    end
    // token aimed at a function address
    task automatic token(input usbeh_tok_t k, input logic [3:0] e, input logic [6:0] a);
        @(posedge clk);
        tok_valid <= 1'b1;
        tok_kind  <= k;
        tok_addr  <= a;
        tok_endp  <= e;
        @(posedge clk);
        tok_valid <= 1'b0;
        // Stale lines must not look like the last token
        tok_addr  <= ~a;
        tok_endp  <= ~e;
        @(posedge clk);
    endtask
    task automatic ack_in(input int w);
        repeat (w) @(posedge clk);
        @(posedge clk);
        tx_acked <= 1'b1;
        @(posedge clk);
        tx_acked <= 1'b0;
        @(posedge clk);
    endtask
    task automatic out_data(input logic d1, input logic [3:0] n);
        @(posedge clk);
        rx_done  <= 1'b1;
        rx_data1 <= d1;
        rx_len   <= n;
        @(posedge clk);
        rx_done  <= 1'b0;
        rx_data1 <= ~d1;
        rx_len   <= ~n;
        @(posedge clk);
    endtask
endmodule

// ===== tb.sv
`timescale 1ns/10ps

// ********************
// Endpoint bench
// ********************
module tb;
    import usbeh_pkg::*;
    logic        clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
    logic [9:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, tok_endp, tx_len, rx_len;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        tok_valid, tx_data1, tx_ep2, tx_acked, rx_done, rx_data1;
    logic [6:0]  tok_addr, func_address;
    logic [7:0]  rq;
    usbeh_tok_t  tok_kind;
    usbeh_hs_t   hs_reply;
    int          n_mismatch, cmp_count, cyc_cnt;
    logic [7:0]  ridx [7] = '{8'h47, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h40};

    usbeh_endpoint dut (
        .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tok_valid(tok_valid),
        .tok_kind(tok_kind), .tok_addr(tok_addr), .tok_endp(tok_endp),
        .hs_reply(hs_reply), .tx_data1(tx_data1), .tx_len(tx_len), .tx_ep2(tx_ep2),
        .tx_acked(tx_acked), .rx_done(rx_done), .rx_data1(rx_data1), .rx_len(rx_len),
        .func_address(func_address), .irq(irq));
    usbeh_host_model host (
        .clk(clk), .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_addr(tok_addr),
        .tok_endp(tok_endp), .tx_acked(tx_acked), .rx_done(rx_done),
        .rx_data1(rx_data1), .rx_len(rx_len));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic summarize;
        $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Generous ceiling; the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h00_0000, d};
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rq = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        wb_dat_i <= ~wb_dat_i;
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00);
        chk(rq, e);
    endtask
    task automatic tk(input usbeh_tok_t k, input logic [3:0] e, input usbeh_hs_t x,
                      input logic [6:0] a = 7'h05);
        host.token(k, e, a);
        chk({6'h00, hs_reply}, {6'h00, x});
    endtask
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge clk);
        chk({7'h00, irq}, {7'h00, e});
    endtask

    initial begin
        rst_b = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        foreach (ridx[i]) rdc(ridx[i], 8'h00);
        wb(1'b0, 8'h4D, 8'h00);
        chk(rq & 8'h30, 8'h00);
        wb(1'b1, 8'h48, 8'h85);
        @(posedge clk);
        chk({1'b0, func_address}, 8'h05);
        tk(USBEH_TOK_IN, 4'h0, USBEH_HS_NAK);
        tk(USBEH_TOK_OUT, 4'h0, USBEH_HS_NAK);
        wb(1'b1, 8'h4B, 8'hB6);
        tk(USBEH_TOK_IN, 4'h0, USBEH_HS_NONE, 7'h06);
        tk(USBEH_TOK_IN, 4'h0, USBEH_HS_ACK);
        chk({7'h00, tx_data1}, 8'h01);
        chk({4'h0, tx_len}, 8'h06);
        host.ack_in(0);
        wb(1'b1, 8'h49, 8'h40);
        rdc(8'h49, 8'h80);
        chk_irq(1'b0);
        tk(USBEH_TOK_IN, 4'h0, USBEH_HS_NAK);
        wb(1'b1, 8'h49, 8'h08);
        chk_irq(1'b1);
        tk(USBEH_TOK_OUT, 4'h0, USBEH_HS_ACK);
        host.out_data(1'b1, 4'h5);
        rdc(8'h49, 8'hC8);
        rdc(8'h4D, 8'hA5);
        tk(USBEH_TOK_OUT, 4'h0, USBEH_HS_NAK);
        wb(1'b1, 8'h49, 8'h06);
        rdc(8'h49, 8'h44);
        chk_irq(1'b1);
        wb(1'b1, 8'h49, 8'h0B);
        rdc(8'h49, 8'h08);
        chk_irq(1'b0);
        wb(1'b1, 8'h4D, 8'h10);
        rdc(8'h4D, 8'h85);
        wb(1'b1, 8'h4B, 8'hF6);
        tk(USBEH_TOK_IN, 4'h0, USBEH_HS_STALL);
        tk(USBEH_TOK_OUT, 4'h0, USBEH_HS_STALL);
        tk(USBEH_TOK_SETUP, 4'h0, USBEH_HS_ACK);
        rdc(8'h4B, 8'hB6);
        rdc(8'h4D, 8'hC5);
        wb(1'b1, 8'h4B, 8'h36);
        tk(USBEH_TOK_IN, 4'h0, USBEH_HS_ACK);
        chk({7'h00, tx_data1}, 8'h00);
        wb(1'b1, 8'h47, 8'h08);
        wb(1'b1, 8'h4C, 8'hA3);
        tk(USBEH_TOK_IN, 4'h2, USBEH_HS_NAK);
        tk(USBEH_TOK_IN, 4'h1, USBEH_HS_NONE);
        wb(1'b1, 8'h4C, 8'hE3);
        tk(USBEH_TOK_IN, 4'h2, USBEH_HS_ACK);
        chk({tx_ep2, tx_data1, 2'b00, tx_len}, 8'hC3);
        host.ack_in(3);
        rdc(8'h4A, 8'h80);
        tk(USBEH_TOK_IN, 4'h2, USBEH_HS_NAK);
        wb(1'b1, 8'h4A, 8'h08);
        chk_irq(1'b1);
        wb(1'b1, 8'h4A, 8'h0A);
        rdc(8'h4A, 8'h08);
        chk_irq(1'b0);
        tk(USBEH_TOK_SOF, 4'h1, USBEH_HS_NONE);
        tk(USBEH_TOK_SETUP, 4'h2, USBEH_HS_NONE);
        wb(1'b1, 8'h47, 8'h09);
        tk(USBEH_TOK_OUT, 4'h1, USBEH_HS_STALL);
        wb(1'b1, 8'h48, 8'h05);
        tk(USBEH_TOK_IN, 4'h0, USBEH_HS_NONE);
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        rdc(8'h4B, 8'h00);
        wb(1'b0, 8'h4D, 8'h00);
        chk(rq & 8'h3F, 8'h05);
        summarize();
    end
endmodule
